// ==== rtl/eaig_top.sv ====
// Function
// - Clearing the alarm group block enable stops every alarm interrupt.
// - An alarm interrupt needs its source enable and its group enable.
// - Clearing the framer group block enable blocks framer interrupts.
// - Status bit 7 reads 1 while out of frame is declared.
// - Out of frame follows a programmed run of bad alignment patterns.
// - Status bit 6 reads 1 while the all-ones alarm is declared.
// - The all-ones alarm is declared after two all-ones frames.
// - It clears after two frames each with more than two zeros.
// - Status bit 5 sets when the multiframe yellow alarm changes.
// - The yellow change flag stays until a status read clears it.
// - Yellow alarm follows the y bit of timeslot 16, frame 0.
// - Status bit 4 reads 1 while signal loss is declared.
// - Signal loss is declared after 175 bits of the loss condition.
// - Loss clears when the condition ends or ones density suffices.
// - The alarm group pending bit falls once the status is read.
module eaig_top (
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        rx_bit_en_in,
  input  wire logic        rx_bit_in,
  input  wire logic        rx_frame_start_in,
  input  wire logic        rx_loss_cond_in,
  input  wire logic        rx_fas_check_in,
  input  wire logic        rx_fas_error_in,
  input  wire logic        rx_mf0_ts16_in,
  input  wire logic        rx_ybit_in,
  input  wire logic        framer_irq_req_in,
  output logic             irq_out
);

  typedef struct packed {
    logic [1:0]  block_en;
    logic [7:0]  src_en;
    logic [2:0]  alignment_loss_count;
    logic        myel_chg;
    logic        myel;
    logic        oof;
    logic [2:0]  fas_bad;
    logic        ais;
    logic [1:0]  ais_run;
    logic [8:0]  zeros;
    logic        los;
    logic [7:0]  los_run;
    logic [7:0]  win;
    logic [7:0]  ones;
    logic [31:0] rdata;
    logic        slverr;
  } eaig_state_t;

  eaig_state_t state_r;
  eaig_state_t state_nxt;

  logic       setup;
  logic       access;
  logic       rd_done;
  logic       wr_done;
  logic       mapped;
  logic [7:0] status;
  logic       alarm_pend;
  logic       framer_pend;
  logic [2:0] alignment_loss_count_lim;
  logic [8:0] zeros_now;
  logic [7:0] ones_now;

  logic        sel_block_en;
  logic        sel_alarm_stat;
  logic        sel_src_en;
  logic        sel_pending;
  logic        sel_frame_ctrl;
  logic        wr_block_en;
  logic        wr_src_en;
  logic        wr_frame_ctrl;
  logic        rd_status;
  logic        status_clear;
  logic [31:0] rd_word;
  logic [7:0]  pend_bits;
  logic        myel_flip;
  logic [3:0]  fas_run_nxt;
  logic        fas_trip;
  logic        zeros_sat;
  logic        frame_all_ones;
  logic        ais_disagree;
  logic        ais_confirm;
  logic        los_declare;
  logic        los_win_end;
  logic        los_dense;

  assign setup  = psel_in && !penable_in;
  assign access = psel_in && penable_in;
  assign sel_block_en   = (paddr_in == eaig_pkg::ADDR_BLOCK_EN);
  assign sel_alarm_stat = (paddr_in == eaig_pkg::ADDR_ALARM_STAT);
  assign sel_src_en     = (paddr_in == eaig_pkg::ADDR_SRC_EN);
  assign sel_pending    = (paddr_in == eaig_pkg::ADDR_PENDING);
  assign sel_frame_ctrl = (paddr_in == eaig_pkg::ADDR_FRAME_CTRL);
  assign mapped  = sel_block_en || sel_alarm_stat || sel_src_en
                || sel_pending || sel_frame_ctrl;
  assign rd_done = access && !pwrite_in;
  assign wr_done = access && pwrite_in && mapped;
  assign wr_block_en   = wr_done && sel_block_en;
  assign wr_src_en     = wr_done && sel_src_en;
  assign wr_frame_ctrl = wr_done && sel_frame_ctrl;
  assign rd_status     = rd_done && sel_alarm_stat;

  // The read word is frozen in the setup cycle, so the access may only
  // clear a change flag that was really handed to software.  A change
  // that lands between setup and access is kept for the next read.
  assign status_clear  = rd_status
                      && state_r.rdata[eaig_pkg::BIT_MYEL_CHG];

  always_comb begin
    status = 8'h00;
    status[eaig_pkg::BIT_OOF_STATE] = state_r.oof;
    status[eaig_pkg::BIT_AIS_STATE] = state_r.ais;
    status[eaig_pkg::BIT_MYEL_CHG]  = state_r.myel_chg;
    status[eaig_pkg::BIT_RX_SIGNAL_LOSS_STATE] = state_r.los;
  end

  // Only the sticky change flag may request an alarm interrupt; live states
  // are visible but would hold the line for as long as a defect lasts.
  // Each status bit is gated by its own enable bit; the mask ties off
  // every enable that has no source behind it.
  for (genvar b = 0; b < 8; b++) begin : g_pend
    assign pend_bits[b] = status[b] & state_r.src_en[b]
                        & eaig_pkg::SRC_EN_MASK[b];
  end
  assign alarm_pend = |pend_bits;
  assign framer_pend = framer_irq_req_in;
  assign irq_out =
      (state_r.block_en[eaig_pkg::BIT_ALARM_EN] && alarm_pend)
   || (state_r.block_en[eaig_pkg::BIT_FRAMER_EN] && framer_pend);

  assign alignment_loss_count_lim  = (state_r.alignment_loss_count == 3'h0) ? 3'h1 : state_r.alignment_loss_count;
  assign zeros_now = (rx_frame_start_in ? 9'h000 : state_r.zeros)
                   + {8'h00, !rx_bit_in};
  assign ones_now  = state_r.ones + {7'h00, rx_bit_in};

  assign myel_flip = rx_mf0_ts16_in && (rx_ybit_in != state_r.myel);

  // One spare bit keeps the run count from wrapping at the top limit.
  assign fas_run_nxt = {1'b0, state_r.fas_bad} + 4'h1;
  assign fas_trip    = fas_run_nxt >= {1'b0, alignment_loss_count_lim};

  // A frame counts as all ones when it carried no more than the allowed
  // zeros; the alarm only moves once the verdict repeats frame on frame.
  assign zeros_sat      = zeros_now > eaig_pkg::AIS_MAX_ZEROS + 9'h001;
  assign frame_all_ones = state_r.zeros <= eaig_pkg::AIS_MAX_ZEROS;
  assign ais_disagree   = frame_all_ones != state_r.ais;
  assign ais_confirm    = state_r.ais_run
                       == 2'(eaig_pkg::AIS_FRAMES - 1);

  // Bits with the loss condition feed the declare counter; once loss is
  // declared, fixed windows of bits judge the ones density.
  assign los_declare = state_r.los_run == eaig_pkg::LOS_BITS - 8'h01;
  assign los_win_end = state_r.win == eaig_pkg::LOS_BITS - 8'h01;
  assign los_dense   = ones_now >= eaig_pkg::LOS_MIN_ONES;

  // Register read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr_in)
      eaig_pkg::ADDR_BLOCK_EN: begin
        rd_word = {30'h0000_0000, state_r.block_en};
      end
      eaig_pkg::ADDR_ALARM_STAT: begin
        rd_word = {24'h00_0000, status};
      end
      eaig_pkg::ADDR_SRC_EN: begin
        rd_word = {24'h00_0000, state_r.src_en};
      end
      eaig_pkg::ADDR_PENDING: begin
        rd_word = {30'h0000_0000, alarm_pend, framer_pend};
      end
      eaig_pkg::ADDR_FRAME_CTRL: begin
        rd_word = {29'h0000_0000, state_r.alignment_loss_count};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  assign pready_out  = access;
  assign prdata_out  = state_r.rdata;
  assign pslverr_out = access && state_r.slverr;

  always_comb begin
    state_nxt = state_r;

    // Read data and the error answer are prepared in the setup cycle.
    if (setup) begin
      state_nxt.slverr = !mapped;
      state_nxt.rdata = rd_word;
    end

    if (wr_block_en) begin
      state_nxt.block_en = pwdata_in[1:0];
    end
    if (wr_src_en) begin
      state_nxt.src_en = pwdata_in[7:0]
                       & eaig_pkg::SRC_EN_MASK;
    end
    if (wr_frame_ctrl) begin
      state_nxt.alignment_loss_count = pwdata_in[2:0];
    end

    // Clear on read first, so that a change in the same cycle wins.
    if (status_clear) begin
      state_nxt.myel_chg = 1'b0;
    end

    if (rx_mf0_ts16_in) begin
      state_nxt.myel = rx_ybit_in;
    end
    if (myel_flip) begin
      state_nxt.myel_chg = 1'b1;
    end

    // Out of frame: count consecutive errored alignment patterns.
    if (rx_fas_check_in) begin
      if (rx_fas_error_in) begin
        if (fas_trip) begin
          state_nxt.oof = 1'b1;
          state_nxt.fas_bad = alignment_loss_count_lim;
        end else begin
          state_nxt.fas_bad = fas_run_nxt[2:0];
        end
      end else begin
        state_nxt.fas_bad = 3'h0;
        state_nxt.oof = 1'b0;
      end
    end

    // All-ones alarm: zeros are counted per frame and judged at the
    // next frame start.
    if (rx_bit_en_in) begin
      if (zeros_sat) begin
        state_nxt.zeros = eaig_pkg::AIS_MAX_ZEROS + 9'h001;
      end else begin
        state_nxt.zeros = zeros_now;
      end
    end else if (rx_frame_start_in) begin
      state_nxt.zeros = 9'h000;
    end

    if (rx_frame_start_in) begin
      if (ais_disagree) begin
        if (ais_confirm) begin
          state_nxt.ais = !state_r.ais;
          state_nxt.ais_run = 2'h0;
        end else begin
          state_nxt.ais_run = state_r.ais_run + 2'h1;
        end
      end else begin
        state_nxt.ais_run = 2'h0;
      end
    end

    // Signal loss: declared on a run of lossy bits, cleared when the
    // loss condition ends or a window of bits carries enough ones.
    if (rx_bit_en_in) begin
      if (!rx_loss_cond_in) begin
        state_nxt.los = 1'b0;
        state_nxt.los_run = 8'h00;
        state_nxt.win = 8'h00;
        state_nxt.ones = 8'h00;
      end else if (!state_r.los) begin
        if (los_declare) begin
          state_nxt.los = 1'b1;
          state_nxt.los_run = 8'h00;
        end else begin
          state_nxt.los_run = state_r.los_run + 8'h01;
        end
      end else if (los_win_end) begin
        state_nxt.los = !los_dense;
        state_nxt.win = 8'h00;
        state_nxt.ones = 8'h00;
      end else begin
        state_nxt.win = state_r.win + 8'h01;
        state_nxt.ones = ones_now;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= '{block_en: eaig_pkg::BLOCK_EN_RST,
                   src_en:   eaig_pkg::SRC_EN_RST,
                   alignment_loss_count:     eaig_pkg::ALIGNMENT_LOSS_COUNT_RST,
                   default:  '0};
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule

// ==== rtl/eaig_pkg.sv ====
package eaig_pkg;
  localparam logic [7:0]  ADDR_BLOCK_EN   = 8'h00;
  localparam logic [7:0]  ADDR_ALARM_STAT = 8'h04;
  localparam logic [7:0]  ADDR_SRC_EN     = 8'h08;
  localparam logic [7:0]  ADDR_PENDING    = 8'h0C;
  localparam logic [7:0]  ADDR_FRAME_CTRL = 8'h10;

  localparam int          BIT_FRAMER_EN   = 0;
  localparam int          BIT_ALARM_EN    = 1;
  localparam int          BIT_RX_SIGNAL_LOSS_STATE   = 4;
  localparam int          BIT_MYEL_CHG    = 5;
  localparam int          BIT_AIS_STATE   = 6;
  localparam int          BIT_OOF_STATE   = 7;

  localparam logic [1:0]  BLOCK_EN_RST    = 2'h0;
  localparam logic [7:0]  SRC_EN_RST      = 8'h00;
  localparam logic [7:0]  SRC_EN_MASK     = 8'h20;
  localparam logic [2:0]  ALIGNMENT_LOSS_COUNT_RST        = 3'h3;

  localparam int          AIS_FRAMES      = 2;
  localparam logic [8:0]  AIS_MAX_ZEROS   = 9'h002;
  localparam logic [7:0]  LOS_BITS        = 8'hAF;
  localparam logic [7:0]  LOS_MIN_ONES    = 8'h16;
endpackage

// ==== test/eaig_top_props.sv ====
module eaig_top_props (
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        rx_mf0_ts16_in,
  input wire logic        rx_ybit_in,
  input wire logic        framer_irq_req_in,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] bie_r;
  logic       src_r;
  logic       ts_r;
  logic       y_r;
  logic       acc;
  logic       fr;
  assign acc = psel_in & penable_in;
  assign fr = bie_r[0] & framer_irq_req_in;
  // Shadow copies of the enables, taken from the same write edges, plus a delayed timeslot 16 strobe and the last y bit.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {bie_r, src_r, ts_r, y_r} <= 5'h00;
    end else begin
      ts_r <= rx_mf0_ts16_in;
      if (rx_mf0_ts16_in) y_r <= rx_ybit_in;
      if (acc && pwrite_in && paddr_in == 8'h00) bie_r <= pwdata_in[1:0];
      if (acc && pwrite_in && paddr_in == 8'h08) src_r <= pwdata_in[5];
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  property p_rdy; pready_out == acc; endproperty
  a_rdy: assert property (p_rdy) else $error("pready wrong");
  property p_err; acc |-> pslverr_out ==
    !(paddr_in inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}); endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_off; !bie_r[1] && !fr |-> !irq_out; endproperty
  a_off: assert property (p_off) else $error("irq not gated");
  property p_frm; fr |-> irq_out; endproperty
  a_frm: assert property (p_frm) else $error("framer irq lost");
  property p_src; !src_r && !fr |-> !irq_out; endproperty
  a_src: assert property (p_src) else $error("source gate");
  property p_hold; irq_out && !bie_r[0] && !acc |=> irq_out; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_clr; acc && !pwrite_in && paddr_in == 8'h04 && !bie_r[0]
    && !rx_mf0_ts16_in && !ts_r |=> !irq_out; endproperty
  a_clr: assert property (p_clr) else $error("not cleared");
  property p_yel; bie_r[1] && src_r && rx_mf0_ts16_in
    && rx_ybit_in != y_r |-> ##[1:2] irq_out; endproperty
  a_yel: assert property (p_yel) else $error("no change irq");
endmodule

bind eaig_top eaig_top_props i_props (.*);

// ==== test/eaig_line_model.sv ====
module eaig_line_model (
  input  wire logic sys_clk_in,
  output logic      en_out,
  output logic      bit_out,
  output logic      fs_out,
  output logic      loss_out,
  output logic      chk_out,
  output logic      err_out,
  output logic      ts_out,
  output logic      y_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {en_out, bit_out, fs_out, loss_out, chk_out, err_out} = 6'h00;
  initial {ts_out, y_out} = 2'h0;
  // Frames of 8 bits; z zeros open each frame, and between bits the
  // line shows the inverse so a stale value is never read as data.
  task automatic bits(input int n, input int z, input logic l, f);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_in);
      {en_out, bit_out, loss_out, fs_out} <=
        {1'b1, (i % 8) >= z, l, f && (i % 8 == 0)};
      @(posedge sys_clk_in);
      {en_out, bit_out, fs_out} <= {1'b0, ~bit_out, 1'b0};
    end
    @(negedge sys_clk_in);
  endtask
  task automatic pulse(input logic t, input logic v);
    @(posedge sys_clk_in);
    if (t) {ts_out, y_out} <= {1'b1, v};
    else {chk_out, err_out} <= {1'b1, v};
    @(posedge sys_clk_in);
    {ts_out, chk_out, y_out, err_out} <= {2'b00, ~y_out, ~err_out};
    @(negedge sys_clk_in);
  endtask
endmodule

// ==== test/e1_alarm_interrupt_gating_test.sv ====
module e1_alarm_interrupt_gating_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic        framer_irq_req_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic [31:0] r;
  logic        pready_out, pslverr_out, irq_out, e;
  logic        rx_bit_en_in, rx_bit_in, rx_frame_start_in, rx_loss_cond_in;
  logic        rx_fas_check_in, rx_fas_error_in, rx_mf0_ts16_in, rx_ybit_in;
  int          error_cnt = 0;
  int          comparisons = 0;
  initial forever #25 sys_clk_in = ~sys_clk_in;
  eaig_line_model i_line (.sys_clk_in(sys_clk_in), .en_out(rx_bit_en_in),
    .bit_out(rx_bit_in), .fs_out(rx_frame_start_in),
    .loss_out(rx_loss_cond_in), .chk_out(rx_fas_check_in),
    .err_out(rx_fas_error_in), .ts_out(rx_mf0_ts16_in), .y_out(rx_ybit_in));
  eaig_top i_dut (.*);
  task automatic chk(input string n, input logic [31:0] s, x);
    comparisons++;
    if (s !== x) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    @(posedge sys_clk_in);
    while (pready_out !== 1'b1) @(posedge sys_clk_in);
    r = prdata_out;
    e = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
    @(negedge sys_clk_in);
  endtask
  task automatic t_regs;
    logic [7:0] a [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk("reg", r, i == 3 ? 32'h3 : 32'h0);
      chk("slverr", e, i == 4);
    end
  endtask
  task automatic t_frm;
    @(posedge sys_clk_in);
    framer_irq_req_in <= 1'b1;
    apb(1'b1, 8'h00, 32'h2);
    chk("irq", irq_out, 1'b0);
    apb(1'b1, 8'h00, 32'h1);
    chk("irq", irq_out, 1'b1);
    @(posedge sys_clk_in);
    framer_irq_req_in <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
  endtask
  task automatic t_yel;
    apb(1'b1, 8'h08, 32'h20);
    apb(1'b1, 8'h00, 32'h2);
    i_line.pulse(1'b1, 1'b1);
    repeat (2) @(negedge sys_clk_in);
    chk("irq", irq_out, 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk("pend", r, 32'h2);
    apb(1'b0, 8'h04, 32'h0);
    chk("yel", r[5], 1'b1);
    chk("irq", irq_out, 1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("pend", r, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    i_line.pulse(1'b1, 1'b0);
    repeat (2) @(negedge sys_clk_in);
    chk("irq", irq_out, 1'b0);
    apb(1'b1, 8'h00, 32'h2);
    chk("irq", irq_out, 1'b1);
    apb(1'b1, 8'h08, 32'h0);
    chk("irq", irq_out, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    i_line.pulse(1'b1, 1'b1);
    fork
      apb(1'b0, 8'h04, 32'h0);
      begin
        @(posedge sys_clk_in);
        i_line.pulse(1'b1, 1'b0);
      end
    join
    chk("yel", r[5], 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk("yel", r[5], 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk("yel", r[5], 1'b0);
    fork
      apb(1'b0, 8'h04, 32'h0);
      i_line.pulse(1'b1, 1'b1);
    join
    chk("yel", r[5], 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk("yel", r[5], 1'b1);
  endtask
  task automatic t_oof_los;
    apb(1'b1, 8'h10, 32'h2);
    for (int i = 0; i < 3; i++) begin
      i_line.pulse(1'b0, i < 2);
      apb(1'b0, 8'h04, 32'h0);
      chk("oof", r[7], i == 1);
      i_line.bits(i == 0 ? 174 : 1, 0, i < 2, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      chk("los", r[4], i == 1);
    end
  endtask
  task automatic t_ais;
    int n [4] = '{9, 1, 16, 1};
    i_line.bits(8, 3, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      i_line.bits(n[i], i == 2 ? 3 : 0, 1'b0, 1'b1);
      apb(1'b0, 8'h04, 32'h0);
      chk("ais", r[6], i == 1 || i == 2);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    t_regs();
    t_frm();
    t_yel();
    t_oof_los();
    t_ais();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    error_cnt++;
    end_of_test();
  end
endmodule
